// ---- design/csc_map.svh ----
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH

// ----------------------------------------
// register selects on the core control port
// ----------------------------------------
`define CSC_SEL_STATUS        1'b0
`define CSC_SEL_CONFIG        1'b1

// ----------------------------------------
// status register fields
// ----------------------------------------
`define CSC_ST_CPU_ID_HI      31
`define CSC_ST_CPU_ID_LO      24
`define CSC_ST_REV_ID_HI      23
`define CSC_ST_REV_ID_LO      16
`define CSC_ST_POWER_DOWN_REQUEST_HI        15
`define CSC_ST_POWER_DOWN_REQUEST_LO        10
`define CSC_ST_SAT_BIT        9
`define CSC_ST_ENDIAN_BIT     8
`define CSC_ST_PCC_HI         7
`define CSC_ST_PCC_LO         5
`define CSC_ST_DCC_HI         4
`define CSC_ST_DCC_LO         2
`define CSC_ST_PREVIOUS_GLOBAL_INT_ENABLE_BIT       1
`define CSC_ST_GIE_BIT        0

// arbitrary neutral identity values
`define CSC_CPU_ID_VALUE      8'hA5
`define CSC_REV_ID_VALUE      8'h01

// ----------------------------------------
// power-down codes
// ----------------------------------------
`define CSC_PD_NONE           6'h00
`define CSC_PD1_ENABLED       6'h09
`define CSC_PD1_ANY           6'h11
`define CSC_PD2               6'h1A
`define CSC_PD3               6'h1C

// ----------------------------------------
// cache mode codes
// ----------------------------------------
`define CSC_CC_MODE_A         3'h0
`define CSC_CC_MODE_B         3'h2

// ----------------------------------------
// configuration register fields
// ----------------------------------------
`define CSC_CF_PRIO_BIT       31
`define CSC_CF_INV_P_BIT      9
`define CSC_CF_INV_D_BIT      8
`define CSC_CF_L2_HI          2
`define CSC_CF_L2_LO          0

`define CSC_L2_SRAM           3'h0
`define CSC_L2_WAY1           3'h1
`define CSC_L2_WAY2           3'h2
`define CSC_L2_WAY3           3'h3
`define CSC_L2_WAY4           3'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define CSC_RST_CACHE_MODE    3'h0
`define CSC_RST_L2_MODE       3'h0
`define CSC_RST_ENDIAN        1'b1

`endif

// ---- design/csc_pkg.sv ----
package csc_pkg;

    typedef enum logic [1:0] {
        CSC_PWR_RUN,
        CSC_PWR_LEVEL1,
        CSC_PWR_LEVEL2,
        CSC_PWR_LEVEL3
    } csc_pwr_state_type;

    typedef struct packed {
        logic        valid;
        logic        sel;
        logic        write;
        logic [31:0] wdata;
    } csc_ctl_req_type;

    typedef struct packed {
        logic       prio_crossbar;
        logic       inval_program;
        logic       inval_data;
        logic [2:0] level2_mode;
        logic [2:0] program_cache_mode;
        logic [2:0] data_cache_mode;
    } csc_cache_ctl_type;

endpackage

// ---- design/csc_l2_arbiter.sv ----
`timescale 1ns/1ns
`include "csc_map.svh"

module csc_l2_arbiter
    import csc_pkg::*;
(
    input  wire logic i_prio_crossbar,
    input  wire logic i_l1d_req,
    input  wire logic i_xbar_req,
    output logic      o_l1d_grant,
    output logic      o_xbar_grant
);

    // ----------------------------------------
    // fixed priority, one winner per cycle
    // ----------------------------------------
    always_comb begin
        if (i_prio_crossbar) begin
            o_xbar_grant = i_xbar_req;                              // [R14]
            o_l1d_grant  = i_l1d_req && !i_xbar_req;                // [R14]
        end else begin
            o_l1d_grant  = i_l1d_req;                               // [R15]
            o_xbar_grant = i_xbar_req && !i_l1d_req;                // [R15]
        end
    end

endmodule

// ---- design/csc_control_regs.sv ----
`timescale 1ns/1ns
`include "csc_map.svh"

// Contract
// [R1] status identity and revision fields are read-only
// [R2] power-down field always reads zero
// [R3] codes 001001/010001 enter level one power-down
// [R4] codes 011010/011100 enter levels two, three
// [R5] saturation bit set by functional units only
// [R6] only control move clears; set beats clear
// [R7] saturation visible one cycle after event; the code stages the event, so sat_reg sets two cycles after it
// [R8] false-condition instruction leaves saturation unchanged
// [R9] endian bit read-only, reports byte order
// [R10] program cache mode accepts 000 or 010
// [R11] data cache mode accepts 000 or 010
// [R12] interrupt taken copies enable into previous-enable
// [R13] global enable gates maskable interrupts, resets 0
// [R14] priority bit set: crossbar beats data cache
// [R15] priority bit clear: data cache beats crossbar
// [R16] writing 1 invalidates program/data cache lines
// [R17] level-2 mode codes 000,001,010,011,111 only
// [R18] config reserved bits ignore writes, read zero
module csc_control_regs
    import csc_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset_n,
    input  wire csc_ctl_req_type   i_ctl_req,
    output logic [31:0]            o_ctl_rdata,
    input  wire logic              i_sat_event,
    input  wire logic              i_sat_cond_true,
    input  wire logic              i_int_taken,
    input  wire logic              i_int_maskable,
    input  wire logic              i_int_any,
    input  wire logic              i_little_endian,
    input  wire logic              i_l1d_req,
    input  wire logic              i_xbar_req,
    output logic                   o_l1d_grant,
    output logic                   o_xbar_grant,
    output logic                   o_int_gated,
    output csc_pwr_state_type      o_power_state,
    output csc_cache_ctl_type      o_cache_ctl
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic              sat_pend_reg;
    logic              sat_pend_next;
    logic              sat_reg;
    logic              sat_next;
    logic              gie_reg;
    logic              gie_next;
    logic              previous_global_int_enable_reg;
    logic              previous_global_int_enable_next;
    logic [2:0]        pcc_reg;
    logic [2:0]        pcc_next;
    logic [2:0]        dcc_reg;
    logic [2:0]        dcc_next;
    logic              prio_reg;
    logic              prio_next;
    logic              inv_p_reg;
    logic              inv_p_next;
    logic              inv_d_reg;
    logic              inv_d_next;
    logic [2:0]        l2_reg;
    logic [2:0]        l2_next;
    logic              endian_reg;
    logic              endian_next;
    logic              endian_meta_reg;
    logic              wake_any_reg;
    logic              wake_any_next;
    csc_pwr_state_type pwr_reg;
    csc_pwr_state_type pwr_next;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    logic              wr_status;
    logic              wr_config;

    function automatic logic cache_mode_ok(input logic [2:0] m);
        cache_mode_ok = (m == `CSC_CC_MODE_A) || (m == `CSC_CC_MODE_B);
    endfunction

    function automatic logic l2_mode_ok(input logic [2:0] m);
        l2_mode_ok = (m == `CSC_L2_SRAM) || (m == `CSC_L2_WAY1) || (m == `CSC_L2_WAY2)
                  || (m == `CSC_L2_WAY3) || (m == `CSC_L2_WAY4);
    endfunction

    assign wr_status = i_ctl_req.valid && i_ctl_req.write && (i_ctl_req.sel == `CSC_SEL_STATUS);
    assign wr_config = i_ctl_req.valid && i_ctl_req.write && (i_ctl_req.sel == `CSC_SEL_CONFIG);

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        // event staged one cycle, so the flag appears a full delay slot later
        sat_pend_next = i_sat_event && i_sat_cond_true;                        // [R7] [R8]
        sat_next      = sat_reg;
        if (wr_status && !i_ctl_req.wdata[`CSC_ST_SAT_BIT]) begin
            sat_next = 1'b0;                                                   // [R6]
        end
        if (sat_pend_reg) begin
            sat_next = 1'b1;                                                   // [R5] [R6]
        end

        gie_next  = gie_reg;
        previous_global_int_enable_next = previous_global_int_enable_reg;
        pcc_next  = pcc_reg;
        dcc_next  = dcc_reg;
        pwr_next  = pwr_reg;
        if (i_int_taken) begin
            previous_global_int_enable_next = gie_reg;                                               // [R12]
            gie_next  = 1'b0;
        end else if (wr_status) begin
            gie_next  = i_ctl_req.wdata[`CSC_ST_GIE_BIT];
            previous_global_int_enable_next = i_ctl_req.wdata[`CSC_ST_PREVIOUS_GLOBAL_INT_ENABLE_BIT];
            // reserved codes keep the previous mode
            if (cache_mode_ok(i_ctl_req.wdata[`CSC_ST_PCC_HI:`CSC_ST_PCC_LO])) begin
                pcc_next = i_ctl_req.wdata[`CSC_ST_PCC_HI:`CSC_ST_PCC_LO];    // [R10]
            end
            if (cache_mode_ok(i_ctl_req.wdata[`CSC_ST_DCC_HI:`CSC_ST_DCC_LO])) begin
                dcc_next = i_ctl_req.wdata[`CSC_ST_DCC_HI:`CSC_ST_DCC_LO];    // [R11]
            end
        end

        case (pwr_reg)
            CSC_PWR_RUN: begin
                if (wr_status) begin
                    case (i_ctl_req.wdata[`CSC_ST_POWER_DOWN_REQUEST_HI:`CSC_ST_POWER_DOWN_REQUEST_LO])
                        `CSC_PD1_ENABLED: pwr_next = CSC_PWR_LEVEL1;          // [R3]
                        `CSC_PD1_ANY:     pwr_next = CSC_PWR_LEVEL1;          // [R3]
                        `CSC_PD2:         pwr_next = CSC_PWR_LEVEL2;          // [R4]
                        `CSC_PD3:         pwr_next = CSC_PWR_LEVEL3;          // [R4]
                        default:          pwr_next = CSC_PWR_RUN;
                    endcase
                end
            end
            CSC_PWR_LEVEL1: begin
                // wake source picked at entry, held until wake-up
                if ((wake_any_reg && i_int_any) || (!wake_any_reg && o_int_gated)) begin
                    pwr_next = CSC_PWR_RUN;                                    // [R3]
                end
            end
            default: begin
                pwr_next = pwr_reg;                                            // [R4]
            end
        endcase

        prio_next  = prio_reg;
        l2_next    = l2_reg;
        inv_p_next = 1'b0;
        inv_d_next = 1'b0;
        if (wr_config) begin
            prio_next  = i_ctl_req.wdata[`CSC_CF_PRIO_BIT];                   // [R14]
            inv_p_next = i_ctl_req.wdata[`CSC_CF_INV_P_BIT];                  // [R16]
            inv_d_next = i_ctl_req.wdata[`CSC_CF_INV_D_BIT];                  // [R16]
            if (l2_mode_ok(i_ctl_req.wdata[`CSC_CF_L2_HI:`CSC_CF_L2_LO])) begin
                l2_next = i_ctl_req.wdata[`CSC_CF_L2_HI:`CSC_CF_L2_LO];       // [R17]
            end
        end

        // strap is asynchronous to the core, so two flops before use
        endian_next = endian_meta_reg;                                         // [R9]

        rdata_next = 32'h0000_0000;
        if (i_ctl_req.sel == `CSC_SEL_STATUS) begin
            rdata_next[`CSC_ST_CPU_ID_HI:`CSC_ST_CPU_ID_LO] = `CSC_CPU_ID_VALUE; // [R1]
            rdata_next[`CSC_ST_REV_ID_HI:`CSC_ST_REV_ID_LO] = `CSC_REV_ID_VALUE; // [R1]
            rdata_next[`CSC_ST_SAT_BIT]                     = sat_reg;
            rdata_next[`CSC_ST_ENDIAN_BIT]                  = endian_reg;        // [R9]
            rdata_next[`CSC_ST_PCC_HI:`CSC_ST_PCC_LO]       = pcc_reg;
            rdata_next[`CSC_ST_DCC_HI:`CSC_ST_DCC_LO]       = dcc_reg;
            rdata_next[`CSC_ST_PREVIOUS_GLOBAL_INT_ENABLE_BIT]                    = previous_global_int_enable_reg;
            rdata_next[`CSC_ST_GIE_BIT]                     = gie_reg;
            // power-down bits stay zero                                           [R2]
        end else begin
            rdata_next[`CSC_CF_PRIO_BIT]           = prio_reg;
            rdata_next[`CSC_CF_L2_HI:`CSC_CF_L2_LO] = l2_reg;                // [R18]
        end
    end

    // ----------------------------------------
    // wake source latch
    // ----------------------------------------
    always_comb begin
        wake_any_next = wake_any_reg;
        if (pwr_reg == CSC_PWR_RUN && wr_status) begin
            wake_any_next = (i_ctl_req.wdata[`CSC_ST_POWER_DOWN_REQUEST_HI:`CSC_ST_POWER_DOWN_REQUEST_LO] == `CSC_PD1_ANY);
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            sat_pend_reg <= 1'b0;
            sat_reg      <= 1'b0;
            gie_reg      <= 1'b0;                                              // [R13]
            previous_global_int_enable_reg     <= 1'b0;                                              // [R12]
            pcc_reg      <= `CSC_RST_CACHE_MODE;
            dcc_reg      <= `CSC_RST_CACHE_MODE;
            prio_reg     <= 1'b0;                                              // [R14]
            inv_p_reg    <= 1'b0;
            inv_d_reg    <= 1'b0;
            l2_reg       <= `CSC_RST_L2_MODE;
            endian_reg   <= `CSC_RST_ENDIAN;
            endian_meta_reg <= `CSC_RST_ENDIAN;
            pwr_reg      <= CSC_PWR_RUN;                                       // [R4]
            rdata_reg    <= 32'h0000_0000;
            wake_any_reg <= 1'b0;
        end else begin
            sat_pend_reg <= sat_pend_next;
            sat_reg      <= sat_next;
            gie_reg      <= gie_next;
            previous_global_int_enable_reg     <= previous_global_int_enable_next;
            pcc_reg      <= pcc_next;
            dcc_reg      <= dcc_next;
            prio_reg     <= prio_next;
            inv_p_reg    <= inv_p_next;
            inv_d_reg    <= inv_d_next;
            l2_reg       <= l2_next;
            endian_reg   <= endian_next;
            endian_meta_reg <= i_little_endian;
            pwr_reg      <= pwr_next;
            rdata_reg    <= rdata_next;
            wake_any_reg <= wake_any_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_int_gated   = i_int_maskable && gie_reg;                          // [R13]
    assign o_ctl_rdata   = rdata_reg;
    assign o_power_state = pwr_reg;

    always_comb begin
        o_cache_ctl.prio_crossbar      = prio_reg;
        o_cache_ctl.inval_program      = inv_p_reg;                            // [R16]
        o_cache_ctl.inval_data         = inv_d_reg;                            // [R16]
        o_cache_ctl.level2_mode        = l2_reg;
        o_cache_ctl.program_cache_mode = pcc_reg;
        o_cache_ctl.data_cache_mode    = dcc_reg;
    end

    csc_l2_arbiter u_arbiter (
        .i_prio_crossbar (prio_reg),
        .i_l1d_req       (i_l1d_req),
        .i_xbar_req      (i_xbar_req),
        .o_l1d_grant     (o_l1d_grant),
        .o_xbar_grant    (o_xbar_grant)
    );

endmodule

// ---- tb/csc_control_regs_monitor.sv ----
`timescale 1ns/1ns
`include "csc_map.svh"

module csc_control_regs_monitor
    import csc_pkg::*;
(
    input wire logic              i_ref_clk,
    input wire logic              i_reset_n,
    input wire csc_ctl_req_type   i_ctl_req,
    input wire logic [31:0]       o_ctl_rdata,
    input wire logic              i_sat_event,
    input wire logic              i_sat_cond_true,
    input wire logic              i_int_taken,
    input wire logic              i_int_maskable,
    input wire logic              i_int_any,
    input wire logic              i_little_endian,
    input wire logic              i_l1d_req,
    input wire logic              i_xbar_req,
    input wire logic              o_l1d_grant,
    input wire logic              o_xbar_grant,
    input wire logic              o_int_gated,
    input wire csc_pwr_state_type o_power_state,
    input wire csc_cache_ctl_type o_cache_ctl
);
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    logic st_wr;
    logic cf_wr;
    assign st_wr = i_ctl_req.valid && i_ctl_req.write && !i_ctl_req.sel;
    assign cf_wr = i_ctl_req.valid && i_ctl_req.write && i_ctl_req.sel;
    sequence sat_hit;
        i_sat_event && i_sat_cond_true;
    endsequence
    // no clear in between, else the flag may legally read zero
    sequence st_read;
        !i_ctl_req.sel && !st_wr;
    endsequence
    chk_sat_delay: assert property (sat_hit ##1 !st_wr ##1 st_read |=> o_ctl_rdata[9])
        else $error("saturation flag not shown");
    chk_id_fixed: assert property (!i_ctl_req.sel |=> o_ctl_rdata[31:16] == {`CSC_CPU_ID_VALUE, `CSC_REV_ID_VALUE})
        else $error("identity field changed");
    chk_power_down_request_zero: assert property (!i_ctl_req.sel |=> o_ctl_rdata[15:10] == 6'h00)
        else $error("power field read nonzero");
    chk_grant_xbar: assert property (o_cache_ctl.prio_crossbar && i_xbar_req |-> o_xbar_grant && !o_l1d_grant)
        else $error("crossbar not preferred");
    chk_grant_l1d: assert property (!o_cache_ctl.prio_crossbar && i_l1d_req |-> o_l1d_grant && !o_xbar_grant)
        else $error("data cache not preferred");
    chk_inval_pulse: assert property (cf_wr && i_ctl_req.wdata[9] |=> o_cache_ctl.inval_program)
        else $error("invalidate pulse missing");
    chk_l2_hold: assert property (cf_wr && i_ctl_req.wdata[2:0] inside {3'h4, 3'h5, 3'h6} |=> $stable(o_cache_ctl.level2_mode))
        else $error("reserved level2 code taken");
    chk_l2_take: assert property (cf_wr && i_ctl_req.wdata[2:0] == `CSC_L2_WAY4 |=> o_cache_ctl.level2_mode == `CSC_L2_WAY4)
        else $error("level2 code not taken");
    chk_deep_stay: assert property (o_power_state == CSC_PWR_LEVEL2 |=> o_power_state == CSC_PWR_LEVEL2)
        else $error("deep power-down left");
    chk_int_taken: assert property (i_int_taken |=> !o_int_gated)
        else $error("enable kept after interrupt");
endmodule

bind csc_control_regs csc_control_regs_monitor i_mon (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_ctl_req(i_ctl_req), .o_ctl_rdata(o_ctl_rdata), .i_sat_event(i_sat_event), .i_sat_cond_true(i_sat_cond_true),
    .i_int_taken(i_int_taken), .i_int_maskable(i_int_maskable), .i_int_any(i_int_any),
    .i_little_endian(i_little_endian), .i_l1d_req(i_l1d_req), .i_xbar_req(i_xbar_req), .o_l1d_grant(o_l1d_grant),
    .o_xbar_grant(o_xbar_grant), .o_int_gated(o_int_gated), .o_power_state(o_power_state), .o_cache_ctl(o_cache_ctl));

// ---- tb/test_cpu_status_cache_config_regs.sv ----
`timescale 1ns/1ns
`include "csc_map.svh"

module test_cpu_status_cache_config_regs;
    import csc_pkg::*;
    // ----------
    // signals
    // ----------
    logic              i_ref_clk, i_reset_n, i_sat_event, i_sat_cond_true, i_int_taken;
    logic              i_int_maskable, i_int_any, i_little_endian, i_l1d_req, i_xbar_req;
    logic              o_l1d_grant, o_xbar_grant, o_int_gated;
    csc_ctl_req_type   i_ctl_req;
    logic [31:0]       o_ctl_rdata, rd_val, d;
    csc_pwr_state_type o_power_state;
    csc_cache_ctl_type o_cache_ctl;
    logic [2:0]        m_pcc, m_dcc, m_l2;
    logic              m_sat, m_en, m_previous_global_int_enable, m_gie, m_prio;
    int                mismatches, checked, cycles, seed;

    csc_control_regs i_csc_control_regs (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_ctl_req(i_ctl_req),
        .o_ctl_rdata(o_ctl_rdata), .i_sat_event(i_sat_event), .i_sat_cond_true(i_sat_cond_true),
        .i_int_taken(i_int_taken), .i_int_maskable(i_int_maskable), .i_int_any(i_int_any),
        .i_little_endian(i_little_endian), .i_l1d_req(i_l1d_req), .i_xbar_req(i_xbar_req),
        .o_l1d_grant(o_l1d_grant), .o_xbar_grant(o_xbar_grant), .o_int_gated(o_int_gated),
        .o_power_state(o_power_state), .o_cache_ctl(o_cache_ctl));

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // whole run is about 150 cycles
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            results();
        end
    end

    // ----------
    // helpers
    // ----------
    task results();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    function logic [31:0] exp_st();
        return {`CSC_CPU_ID_VALUE, `CSC_REV_ID_VALUE, 6'h00, m_sat, m_en, m_pcc, m_dcc, m_previous_global_int_enable, m_gie};
    endfunction

    task wr(input logic sel, input logic [31:0] data);
        @(negedge i_ref_clk);
        i_ctl_req = '{1'b1, sel, 1'b1, data};
        @(negedge i_ref_clk);
        i_ctl_req.valid = 1'b0;
        i_ctl_req.write = 1'b0;
    endtask

    task rd(input logic sel);
        @(negedge i_ref_clk);
        i_ctl_req.sel = sel;
        @(negedge i_ref_clk);
        rd_val = o_ctl_rdata;
    endtask

    task chk_st();
        rd(1'b0);
        check("status", exp_st(), rd_val);
    endtask

    task wst(input logic [5:0] pd);
        d = exp_st();
        d[15:10] = pd;
        wr(1'b0, d);
    endtask

    task do_reset();
        i_reset_n = 1'b0;
        repeat (10) @(negedge i_ref_clk);
        i_reset_n = 1'b1;
        {m_pcc, m_dcc, m_l2, m_sat, m_previous_global_int_enable, m_gie, m_prio} = '0;
    endtask

    // ----------
    // scenarios
    // ----------
    initial begin
        {i_sat_event, i_sat_cond_true, i_int_taken, i_int_maskable, i_int_any, i_l1d_req, i_xbar_req} = '0;
        i_ctl_req = '0;
        i_little_endian = 1'b1;
        m_en = 1'b1;
        {seed, mismatches, checked, cycles} = {32'd88907, 96'h0};
        do_reset();
        chk_st();
        rd(1'b1);
        check("config", 32'h0, rd_val & 32'h8000_00FF);
        wr(1'b0, 32'hFFFF_FFFF);
        {m_previous_global_int_enable, m_gie} = 2'b11;
        chk_st();
        check("power", CSC_PWR_RUN, o_power_state);
        for (int c = 0; c < 8; c++) begin
            d = $random(seed);
            d[15:2] = {6'h00, 2'b11, c[2:0], c[2:0]};
            wr(1'b0, d);
            if (c == 0 || c == 2) {m_pcc, m_dcc} = {c[2:0], c[2:0]};
            {m_previous_global_int_enable, m_gie} = d[1:0];
            chk_st();
            d = $random(seed);
            {d[31], d[2:0]} = {c[0], c[2:0]};
            wr(1'b1, d);
            check("inval_p", d[9], o_cache_ctl.inval_program);
            check("inval_d", d[8], o_cache_ctl.inval_data);
            m_prio = c[0];
            if (c[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7}) m_l2 = c[2:0];
            rd(1'b1);
            check("config", {m_prio, 28'h0, m_l2}, rd_val & 32'h8000_00FF);
            for (int r = 0; r < 4; r++) begin
                {i_l1d_req, i_xbar_req} = r[1:0];
                #1;
                check("l1d_grant", i_l1d_req && !(m_prio && i_xbar_req), o_l1d_grant);
                check("xbar_grant", i_xbar_req && !(!m_prio && i_l1d_req), o_xbar_grant);
            end
        end
        // saturation: false condition, true condition, set against clear
        @(negedge i_ref_clk);
        i_sat_event = 1'b1;
        @(negedge i_ref_clk);
        i_sat_event = 1'b0;
        chk_st();
        i_sat_cond_true = 1'b1;
        @(negedge i_ref_clk);
        i_sat_event = 1'b1;
        @(negedge i_ref_clk);
        i_sat_event = 1'b0;
        @(negedge i_ref_clk);
        m_sat = 1'b1;
        chk_st();
        d = exp_st();
        d[9] = 1'b0;
        wr(1'b0, d);
        m_sat = 1'b0;
        chk_st();
        // clear lands in the very cycle the staged set does
        @(negedge i_ref_clk);
        i_sat_event = 1'b1;
        @(negedge i_ref_clk);
        i_ctl_req = '{1'b1, 1'b0, 1'b1, d};
        i_sat_event = 1'b0;
        @(negedge i_ref_clk);
        {i_ctl_req.valid, i_ctl_req.write} = 2'b00;
        m_sat = 1'b1;
        chk_st();
        // interrupt enable and its saved copy
        {m_previous_global_int_enable, m_gie} = 2'b01;
        wst(`CSC_PD_NONE);
        i_int_maskable = 1'b1;
        #1 check("gated", 32'h1, o_int_gated);
        @(negedge i_ref_clk);
        i_int_taken = 1'b1;
        @(negedge i_ref_clk);
        i_int_taken = 1'b0;
        {m_previous_global_int_enable, m_gie} = 2'b10;
        check("gated", 32'h0, o_int_gated);
        i_int_maskable = 1'b0;
        chk_st();
        // power-down codes and wake conditions
        m_gie = 1'b1;
        wst(`CSC_PD1_ENABLED);
        check("power", CSC_PWR_LEVEL1, o_power_state);
        i_int_any = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        check("power", CSC_PWR_LEVEL1, o_power_state);
        i_int_maskable = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        check("power", CSC_PWR_RUN, o_power_state);
        {i_int_any, i_int_maskable, m_gie} = 3'b000;
        wst(`CSC_PD1_ANY);
        check("power", CSC_PWR_LEVEL1, o_power_state);
        i_int_any = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        check("power", CSC_PWR_RUN, o_power_state);
        i_int_any = 1'b0;
        wst(`CSC_PD2);
        check("power", CSC_PWR_LEVEL2, o_power_state);
        {i_int_any, i_int_maskable} = 2'b11;
        wst(`CSC_PD_NONE);
        repeat (2) @(negedge i_ref_clk);
        check("power", CSC_PWR_LEVEL2, o_power_state);
        {i_int_any, i_int_maskable} = 2'b00;
        do_reset();
        wst(`CSC_PD3);
        check("power", CSC_PWR_LEVEL3, o_power_state);
        do_reset();
        check("power", CSC_PWR_RUN, o_power_state);
        {i_little_endian, m_en} = 2'b00;
        repeat (2) @(negedge i_ref_clk);
        chk_st();
        results();
    end
endmodule
